// ---- core/sfa_pkg.sv ----
// shared constants and frame types for the serial frame adc sequencer
package sfa_pkg;
  // link frame
  localparam int FRAME_BITS = 16;
  localparam int BIT_CFG = 0;
  localparam int BIT_START = 1;
  localparam int BIT_SEL_LO = 2;
  localparam int BIT_GATE = 5;
  localparam int BIT_AUX1 = 14;
  localparam int BIT_AUX2 = 15;
  localparam int CFG_BIT_INFO_FRAME_REQUEST = 1;
  localparam int CFG_BIT_SPEED = 3;
  localparam int CFG_BIT_DCSS = 4;
  localparam int OUT_BIT_INFO = 7;
  // conversion pacing
  localparam int SAMPLE_SCLK = 15;
  localparam int CONV_FRAMES_FAST = 4;
  localparam int CONV_FRAMES_SLOW = 8;
  // reset values
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam logic [7:0] RESULT_RST = 8'h00;
  // reported input codes
  localparam logic [2:0] CODE_GEN0 = 3'h0;
  localparam logic [2:0] CODE_GEN1 = 3'h1;
  localparam logic [2:0] CODE_DIR2 = 3'h2;
  localparam logic [2:0] CODE_DIR3 = 3'h3;
  localparam logic [2:0] CODE_CHA = 3'h4;
  localparam logic [2:0] CODE_CHB = 3'h5;
  localparam logic [2:0] CODE_CHA_INV = 3'h6;
  localparam logic [2:0] CODE_CHB_INV = 3'h7;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_OUTS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // normal input frame layout
  typedef struct packed {
    logic aux2;
    logic aux1;
    logic [3:0] phase;
    logic [1:0] dir_a;
    logic [1:0] dir_b;
    logic gate;
    logic [2:0] sel;
    logic start;
    logic cfg;
  } sfa_nframe_t;

  // normal output frame layout
  typedef struct packed {
    logic [7:0] result;
    logic info;
    logic [2:0] code;
    logic enc_b;
    logic enc_a;
    logic done2;
    logic done1;
  } sfa_oframe_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} sfa_state_t;
endpackage

// ---- core/sfa_sequencer.sv ----
// serial frame decoder and adc conversion sequencer with axi4-lite status port
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module sfa_sequencer
  import sfa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic encoder_phase_a,
  input wire logic encoder_phase_b,
  input wire logic [7:0] conv_data_in,
  output logic [2:0] conv_input_sel,
  output logic sample_hold,
  output logic [1:0] hs_out,
  output logic [1:0] ls_out,
  output logic [3:0] step_phase,
  output logic [5:0] motor_level,
  output logic [2:0] motor_force,
  output logic gate_drive_output,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // two-flop synchronisers; stage 2 also feeds the edge detectors
  logic [2:0] sclk_s_r, ce_s_r, mosi_s_r;
  logic [1:0] enca_s_r, encb_s_r;
  always_ff @(posedge aclk)
  begin
    sclk_s_r <= {sclk_s_r[1:0], sclk};
    ce_s_r <= {ce_s_r[1:0], ce_n};
    mosi_s_r <= {mosi_s_r[1:0], mosi};
    enca_s_r <= {enca_s_r[0], encoder_phase_a};
    encb_s_r <= {encb_s_r[0], encoder_phase_b};
  end

  // link events
  wire active = ~ce_s_r[1];
  wire sclk_rise = active & sclk_s_r[1] & ~sclk_s_r[2];
  wire sclk_fall = active & ~sclk_s_r[1] & sclk_s_r[2];
  wire fr_start = ce_s_r[2] & ~ce_s_r[1];
  wire fr_stop = ~ce_s_r[2] & ce_s_r[1];

  logic [4:0] bit_cnt_r;
  logic [15:0] rx_r, tx_r;
  logic hold_r, speed_r, dcss_r, info_pend_r;
  logic done1_pend_r, done2_pend_r;
  logic [7:0] result_r, sampled_r;
  logic [2:0] code_r, sel_r;
  sfa_state_t state_r;
  logic [3:0] frames_r;
  logic [3:0] samp_cnt_r;
  sfa_nframe_t nf_r;

  // frame decode; short frames are dropped whole
  wire fr_done = fr_stop & (bit_cnt_r == 5'(FRAME_BITS));
  wire is_cfg = fr_done & rx_r[BIT_CFG];
  wire is_norm = fr_done & ~rx_r[BIT_CFG];
  wire start_req = is_norm & rx_r[BIT_START] & ~hold_r;
  wire [2:0] new_sel = rx_r[BIT_SEL_LO +: 3];

  // conversion pacing
  wire [3:0] conv_frames = speed_r ? 4'(CONV_FRAMES_SLOW) : 4'(CONV_FRAMES_FAST);
  wire busy = (state_r != ST_IDLE);
  wire conv_end = busy & fr_done & (frames_r == conv_frames - 4'h1);
  wire is_pair = sel_r[2];
  wire more = conv_end & (state_r == ST_FIRST) & is_pair;
  wire seq_end = conv_end & ~more;
  // a start landing on the final frame chains straight on
  wire accept = start_req & (~busy | seq_end);

  // input code for the conversion in hand
  wire enc_diff = enca_s_r[1] ^ encb_s_r[1];
  wire [2:0] auto_code = enca_s_r[1] ? (enc_diff ? CODE_CHA : CODE_CHB)
                                     : (enc_diff ? CODE_CHA_INV : CODE_CHB_INV);
  wire second = (state_r == ST_SECOND);
  logic [2:0] cur_code;
  // pair order is fixed per selection code
  always_comb
  begin
    case (sel_r)
      3'h0: cur_code = CODE_GEN0;
      3'h1: cur_code = CODE_GEN1;
      3'h4: cur_code = second ? CODE_CHB : CODE_CHA;
      3'h5: cur_code = second ? CODE_CHA_INV : CODE_CHA;
      3'h6: cur_code = second ? CODE_CHB_INV : CODE_CHB;
      3'h7: cur_code = second ? CODE_DIR3 : CODE_DIR2;
      default: cur_code = auto_code;
    endcase
  end
  assign conv_input_sel = cur_code;

  // bit counter and receive shift, msb first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bit_cnt_r <= 5'h00;
    else if (fr_start)
      bit_cnt_r <= 5'h00;
    else if (sclk_rise && bit_cnt_r != 5'h1f)
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_r <= FRAME_RST;
    else if (sclk_rise)
      rx_r <= {rx_r[14:0], mosi_s_r[1]};
  end

  // returned frame, loaded at chip enable fall
  sfa_oframe_t out_w;
  assign out_w = '{result: result_r, info: 1'b0, code: code_r, enc_b: encb_s_r[1], enc_a: enca_s_r[1],
                   done2: done2_pend_r, done1: done1_pend_r};
  wire [15:0] info_w = 16'h0001 << OUT_BIT_INFO;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_r <= FRAME_RST;
    else if (fr_start)
      tx_r <= info_pend_r ? info_w : out_w;
    else if (sclk_fall)
      tx_r <= {tx_r[14:0], 1'b0};
  end
  assign miso = tx_r[15];
  assign miso_oe_n = ~active;

  // config bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      speed_r <= 1'b0;
      dcss_r <= 1'b0;
    end
    else if (is_cfg)
    begin
      speed_r <= rx_r[CFG_BIT_SPEED];
      dcss_r <= rx_r[CFG_BIT_DCSS];
    end
  end

  // info request serves the next frame only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      info_pend_r <= 1'b0;
    else if (is_cfg && rx_r[CFG_BIT_INFO_FRAME_REQUEST])
      info_pend_r <= 1'b1;
    else if (fr_start)
      info_pend_r <= 1'b0;
  end

  // latched normal frame controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nf_r <= FRAME_RST;
    else if (is_norm)
      nf_r <= rx_r;
  end

  // output decode; dcss low is dc mode with low side outputs
  wire [1:0] aux = {nf_r.aux2, nf_r.aux1};
  assign ls_out = dcss_r ? 2'h0 : aux;
  assign hs_out = dcss_r ? aux : 2'h0;
  assign step_phase = dcss_r ? nf_r.phase : 4'h0;
  assign motor_level = {nf_r.phase[1:0], nf_r.dir_a, nf_r.dir_b};
  assign motor_force = {~^nf_r.phase[1:0], ~^nf_r.dir_a, ~^nf_r.dir_b};
  assign gate_drive_output = nf_r.gate;

  // sequencer state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      sel_r <= 3'h0;
    end
    else if (accept)
    begin
      state_r <= ST_FIRST;
      sel_r <= new_sel;
    end
    else if (more)
      state_r <= ST_SECOND;
    else if (seq_end)
      state_r <= ST_IDLE;
  end

  // frame count per conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn || accept || conv_end)
      frames_r <= 4'h0;
    else if (busy && fr_done)
      frames_r <= frames_r + 4'h1;
  end

  // sample window counts serial clock rises
  always_ff @(posedge aclk)
  begin
    if (!aresetn || accept || more)
      samp_cnt_r <= 4'h0;
    else if (busy && sclk_rise && samp_cnt_r != 4'(SAMPLE_SCLK))
      samp_cnt_r <= samp_cnt_r + 4'h1;
  end
  assign sample_hold = busy && samp_cnt_r != 4'(SAMPLE_SCLK);

  // value held when sampling closes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sampled_r <= RESULT_RST;
    else if (sample_hold && sclk_rise && samp_cnt_r == 4'(SAMPLE_SCLK - 1))
      sampled_r <= conv_data_in;
  end

  // publish result and code on completion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_r <= RESULT_RST;
      code_r <= 3'h0;
    end
    else if (conv_end)
    begin
      result_r <= sampled_r;
      code_r <= cur_code;
    end
  end

  // done flags: completion beats the clear by frame load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done1_pend_r <= 1'b0;
      done2_pend_r <= 1'b0;
    end
    else
    begin
      done1_pend_r <= (conv_end && !second) || (done1_pend_r && !fr_start);
      done2_pend_r <= (conv_end && second) || (done2_pend_r && !fr_start);
    end
  end

  // axi4-lite write path; address and data taken in either order
  logic aw_got_r, w_got_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  wire do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_got_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (do_wr)
        w_got_r <= 1'b0;
    end
  end

  // control: bit 0 blocks new starts, the status readback stays live
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      if (awaddr_r == REG_CTRL && wstrb_r[0])
        hold_r <= wdata_r[0];
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read path, one cycle answer
  wire [31:0] status_w = {8'h00, result_r, 1'b0, code_r, 1'b0, sel_r, 1'b0, info_pend_r,
                          dcss_r, speed_r, state_r, done2_pend_r, done1_pend_r};
  wire rd_map = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_STATUS || s_axi_araddr == REG_OUTS;
  wire [31:0] rd_w = (s_axi_araddr == REG_CTRL) ? {31'h0, hold_r} :
                     (s_axi_araddr == REG_STATUS) ? status_w :
                     (s_axi_araddr == REG_OUTS) ? {16'h0, nf_r} : 32'h0;
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_w;
      s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_while_busy: assert property (start_req && busy && !seq_end |=> $stable(sel_r) && busy)
    else $error("start accepted during conversion");
  a_start_begins: assert property (start_req && !busy |=> state_r == ST_FIRST && sel_r == $past(new_sel))
    else $error("start did not begin conversion");
  a_done_one_frame: assert property (done1_pend_r && fr_start |=> !done1_pend_r [*2])
    else $error("first done flag held past one frame");
  a_pair_second: assert property ($rose(done2_pend_r) |-> $past(state_r) == ST_SECOND && $past(is_pair))
    else $error("second done without pair");
  a_pace_frames: assert property (conv_end |-> fr_done &&
    frames_r == (speed_r ? 4'(CONV_FRAMES_SLOW - 1) : 4'(CONV_FRAMES_FAST - 1)))
    else $error("conversion length wrong");
  a_sample_window: assert property (accept |=> sample_hold && samp_cnt_r == 4'h0)
    else $error("sampling window not opened");
  a_gate_follow: assert property (is_norm |=> gate_drive_output == $past(rx_r[BIT_GATE]))
    else $error("gate output not following frame");
  a_cfg_no_ctrl: assert property (is_cfg |=> $stable(nf_r))
    else $error("config frame changed controls");
  a_result_load: assert property (conv_end |=> result_r == $past(sampled_r) && code_r == $past(cur_code))
    else $error("result not published");

  c_pair_done: cover property ($rose(done2_pend_r));
  c_chained: cover property (start_req && seq_end);
  c_ignored: cover property (start_req && busy && !seq_end);
endmodule

// ---- tb/sfa_host_model.sv ----
// host serial master model: one 16-bit exchange per chip enable
module sfa_host_model
  import sfa_pkg::*;
(
  input wire logic aclk,
  output logic sclk,
  output logic ce_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: deselected, clock at rest
  initial
  begin
    sclk = 1'b0;
    ce_n = 1'b1;
    mosi = 1'b0;
  end

  // msb first; data set while clock low, reply taken after the rising edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge aclk);
    ce_n <= 1'b0;
    repeat (6) @(posedge aclk);
    for (int i = 15; i >= 0; i--)
    begin
      mosi <= tx[i];
      repeat (4) @(posedge aclk);
      sclk <= 1'b1;
      @(negedge aclk);
      rx[i] = miso;
      repeat (4) @(posedge aclk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    ce_n <= 1'b1;
    // no pull on the data line, so show the inverse instead of a stale bit
    mosi <= ~tx[0];
    repeat (6) @(posedge aclk);
  endtask
endmodule

// ---- tb/sfa_sequencer_tb_top.sv ----
// self-checking bench for the frame decoder and conversion sequencer
module sfa_sequencer_tb_top
  import sfa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sclk, ce_n, mosi, miso, miso_oe_n, sample_hold, gate_drive_output;
  logic encoder_phase_a = 1'b1;
  logic encoder_phase_b = 1'b0;
  logic [7:0] conv_data_in = 8'h00;
  logic [2:0] conv_input_sel, motor_force;
  logic [1:0] hs_out, ls_out, s_axi_bresp, s_axi_rresp;
  logic [3:0] step_phase;
  logic [5:0] motor_level;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  sfa_sequencer dut (.*);
  sfa_host_model host (.aclk(aclk), .sclk(sclk), .ce_n(ce_n), .mosi(mosi), .miso(miso));

  always #10 aclk = ~aclk;

  // converter value tracks the addressed input, so a wrong mux shows in the result
  always @(posedge aclk)
    conv_data_in <= {5'h16, conv_input_sel};

  task automatic report_and_stop;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, well above the longest expected run
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    // each channel released only at its own handshake edge
    while (pa || pw)
    begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk) s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk) s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk) s_axi_rready <= 1'b0;
  endtask

  function automatic sfa_nframe_t mk(input logic [2:0] s, input logic st);
    mk = '0;
    mk.sel = s;
    mk.start = st;
  endfunction

  task automatic xf(input sfa_nframe_t f, output sfa_oframe_t o);
    logic [15:0] r;
    host.xfer(f, r);
    o = r;
  endtask

  // power-up values, register access kinds, unmapped places
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_STATUS, d, r);
    chk("status rst", d, 32'h0);
    axi_rd(4'hc, d, r);
    chk("unmapped rresp", r, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h1, r);
    chk("ro bresp", r, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h0, r);
    chk("ctrl bresp", r, RESP_OKAY);
    chk("gate rst", gate_drive_output, 1'b0);
  endtask

  // level controls decoded from a normal frame, then in step mode
  task automatic t_outputs;
    sfa_nframe_t f;
    sfa_oframe_t o;
    logic [31:0] d;
    logic [1:0] r;
    f = '0;
    {f.aux2, f.aux1, f.phase, f.dir_a, f.dir_b, f.gate} = {2'b10, 4'ha, 2'b11, 2'b01, 1'b1};
    xf(f, o);
    chk("enc bits", {o.enc_b, o.enc_a}, 2'b01);
    chk("gate", gate_drive_output, 1'b1);
    chk("levels", motor_level, 6'h2d);
    chk("force", motor_force, 3'b010);
    chk("ls", {ls_out, hs_out}, 4'h8);
    chk("oe idle", miso_oe_n, 1'b1);
    axi_rd(REG_OUTS, d, r);
    chk("outs", d, {16'h0, f});
    xf(16'h0011, o);
    chk("cfg not normal", gate_drive_output, 1'b1);
    xf(f, o);
    chk("hs", {hs_out, ls_out}, 4'h8);
    chk("phase", step_phase, 4'ha);
    f.gate = 1'b0;
    xf(f, o);
    chk("gate off", gate_drive_output, 1'b0);
  endtask

  // one start, a dropped start mid-way, then quiet frames
  task automatic run_conv(input logic [2:0] s, input int n, input logic [2:0] c1, input logic [2:0] c2,
                          input logic pair);
    sfa_oframe_t o;
    xf(mk(s, 1'b1), o);
    chk("sample open", sample_hold, 1'b1);
    for (int k = 1; k <= 2 * n + 2; k++)
    begin
      xf(mk(~s, k == 2), o);
      chk("done1", o.done1, k == n + 1);
      chk("done2", o.done2, pair && k == 2 * n + 1);
      if (k == 1 || k == n)
        chk("sample window", sample_hold, pair && k == n);
      if (k == n + 1 || k == n + 2)
        chk("first", {o.code, o.result}, {c1, 5'h16, c1});
      if (pair && k == 2 * n + 1)
        chk("second", {o.code, o.result}, {c2, 5'h16, c2});
    end
  endtask

  // selection codes 0, 1 and 3 to 7, auto pick from both phase settings, then slow pacing
  task automatic t_conv;
    sfa_oframe_t o;
    run_conv(3'h0, 4, CODE_GEN0, 3'h0, 1'b0);
    run_conv(3'h1, 4, CODE_GEN1, 3'h0, 1'b0);
    run_conv(3'h3, 4, CODE_CHA, 3'h0, 1'b0);
    @(posedge aclk) encoder_phase_b <= 1'b1;
    run_conv(3'h3, 4, CODE_CHB, 3'h0, 1'b0);
    run_conv(3'h4, 4, CODE_CHA, CODE_CHB, 1'b1);
    run_conv(3'h5, 4, CODE_CHA, CODE_CHA_INV, 1'b1);
    run_conv(3'h6, 4, CODE_CHB, CODE_CHB_INV, 1'b1);
    run_conv(3'h7, 4, CODE_DIR2, CODE_DIR3, 1'b1);
    // no info request while converting
    xf(16'h0009, o);
    run_conv(3'h1, 8, CODE_GEN1, 3'h0, 1'b0);
  endtask

  // info frame on request, then starts refused while the hold bit is set
  task automatic t_hold;
    sfa_oframe_t o;
    logic [31:0] d;
    logic [1:0] r;
    xf(16'h0003, o);
    xf(mk(3'h0, 1'b0), o);
    chk("info frame", o, 16'h0080);
    axi_wr(REG_CTRL, 32'h1, r);
    xf(mk(3'h0, 1'b1), o);
    axi_rd(REG_STATUS, d, r);
    chk("held state", d[3:2], 2'h0);
    axi_wr(REG_CTRL, 32'h0, r);
  endtask

  // start in the completing frame chains the next conversion at fast pacing
  task automatic t_chain;
    sfa_oframe_t o;
    logic [2:0] c;
    xf(mk(3'h0, 1'b1), o);
    for (int k = 1; k <= 9; k++)
    begin
      xf(mk(3'h1, k == 4), o);
      chk("chain done1", o.done1, k == 5 || k == 9);
      c = (k == 9) ? CODE_GEN1 : CODE_GEN0;
      if (k == 5 || k == 9)
        chk("chain result", {o.code, o.result}, {c, 5'h16, c});
    end
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_regs();
    t_outputs();
    t_conv();
    t_hold();
    t_chain();
    report_and_stop();
  end
endmodule
